// ### src/mmc_config.v
// Function
// RULE_01 - Bit 1 picks continuous (0, reset) or cycle (1) monitoring.
// RULE_02 - Bit 2 makes shared pin the alert output; 0 keeps address-or-reset role.
// RULE_03 - Bit 3 set lets voltage faults drive alert pin low; clear ignores them.
// RULE_04 - Bit 4 routes temperature offset: 0 external channels, 1 internal.
// RULE_05 - Bit 5 clear: remote diodes average 128, others average 8.
// RULE_06 - Bit 5 set: remote diodes average 16, others single sample.
// RULE_07 - Bits 7 and 6 are read-only zero.
// RULE_08 - Read-as-one bits ignore writes and always read one.
// RULE_09 - Bit 0 picks sleep (0, reset) or shutdown (1) low-power state.
// RULE_10 - Averaging and mode changes apply from next conversion sequence only.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "mmc_consts.vh"
module mmc_config (
   input wire mclk, // 125 MHz clock
   input wire rstn, // Async reset, active low
   input wire init_n, // Initialization request, active low, async pin
   input wire [`MMC_ADDR_W-1:0] reg_addr, // Register address
   input wire [7:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   output reg [7:0] reg_rdata, // Read data, cycle after strobe
   input wire seq_start, // Engine starts a conversion sequence, pulse
   input wire volt_fault, // Voltage reading at or beyond limit
   input wire temp_fault, // Temperature reading at or beyond limit
   input wire vid_pin_role, // Bit 7 of voltage identification register
   output reg low_power_shutdown, // 1 shutdown, 0 sleep
   output reg cycle_monitor, // 1 cycle mode, 0 continuous
   output reg offset_to_internal, // Offset applies to internal channel
   output reg [7:0] remote_avg_count, // Samples averaged per remote diode value
   output reg [7:0] other_avg_count, // Samples averaged per voltage/internal value
   output wire alert_pin_o, // Shared pin output level
   output wire alert_pin_oe, // Shared pin driven low when high
   output wire pin_role_alert, // 1 over-limit alert, 0 address-or-reset role
   output wire pin_role_pulse, // Address-or-reset role selection
   output wire irq // Level interrupt
);
   reg [7:0] config_q;
   reg [`MMC_ST_W-1:0] status;
   reg [`MMC_ST_W-1:0] mask;
   reg init_s1;
   reg init_s2;
   reg volt_s1;
   reg volt_s2;
   reg temp_s1;
   reg temp_s2;
   reg volt_d;
   reg temp_d;
   wire [`MMC_ST_W-1:0] events;
   wire [7:0] next_config;
   wire over_limit;

   // Fault inputs come from the analog side, so they are synchronised
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         init_s1 <= 1'b1;
         init_s2 <= 1'b1;
         volt_s1 <= 1'b0;
         volt_s2 <= 1'b0;
         temp_s1 <= 1'b0;
         temp_s2 <= 1'b0;
         volt_d <= 1'b0;
         temp_d <= 1'b0;
      end else begin
         init_s1 <= init_n;
         init_s2 <= init_s1;
         volt_s1 <= volt_fault;
         volt_s2 <= volt_s1;
         temp_s1 <= temp_fault;
         temp_s2 <= temp_s1;
         volt_d <= volt_s2;
         temp_d <= temp_s2;
      end
   end

   // Reserved bits are never stored
   assign next_config = reg_wdata & `MMC_CONFIG_WMASK; // RULE_07

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         config_q <= `MMC_CONFIG_RESET;
      end else if (!init_s2) begin
         config_q <= `MMC_CONFIG_RESET;
      end else if (reg_wr && reg_addr == `MMC_OFF_CONFIG) begin
         config_q <= next_config;
      end
   end

   // Mode and averaging shadows load at a sequence boundary; initialization reloads their reset values
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cycle_monitor <= 1'b0;
         remote_avg_count <= `MMC_AVG_REMOTE_SLOW;
         other_avg_count <= `MMC_AVG_OTHER_SLOW;
      end else if (!init_s2) begin
         cycle_monitor <= 1'b0;
         remote_avg_count <= `MMC_AVG_REMOTE_SLOW;
         other_avg_count <= `MMC_AVG_OTHER_SLOW;
      end else if (seq_start) begin // RULE_10
         cycle_monitor <= config_q[`MMC_BIT_CYCLE]; // RULE_01
         if (config_q[`MMC_BIT_FAST_AVG]) begin
            remote_avg_count <= `MMC_AVG_REMOTE_FAST; // RULE_06
            other_avg_count <= `MMC_AVG_OTHER_FAST; // RULE_06
         end else begin
            remote_avg_count <= `MMC_AVG_REMOTE_SLOW; // RULE_05
            other_avg_count <= `MMC_AVG_OTHER_SLOW; // RULE_05
         end
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_power_shutdown <= 1'b0;
         offset_to_internal <= 1'b0;
      end else begin
         low_power_shutdown <= config_q[`MMC_BIT_SHUTDOWN]; // RULE_09
         offset_to_internal <= config_q[`MMC_BIT_OFS_INT]; // RULE_04
      end
   end

   // Alert pin: open drain, pulled low while enabled and a temperature fault, or a voltage fault with bit 3 set, stands
   assign pin_role_alert = config_q[`MMC_BIT_ALERT_EN]; // RULE_02
   assign pin_role_pulse = vid_pin_role; // RULE_02
   assign over_limit = temp_s2 | (config_q[`MMC_BIT_VOLT_ALERT] & volt_s2); // RULE_03
   assign alert_pin_o = 1'b0;
   assign alert_pin_oe = pin_role_alert & over_limit; // RULE_02

   assign events[`MMC_ST_SEQ_DONE] = seq_start;
   assign events[`MMC_ST_VOLT_FAULT] = volt_s2 & ~volt_d;
   assign events[`MMC_ST_TEMP_FAULT] = temp_s2 & ~temp_d;

   // Sticky status per bit; a new event wins over a write-one clear
   genvar gi;
   generate
      for (gi = 0; gi < `MMC_ST_W; gi = gi + 1) begin : g_status
         always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               status[gi] <= 1'b0;
            end else if (events[gi]) begin
               status[gi] <= 1'b1;
            end else if (reg_wr && reg_addr == `MMC_OFF_STATUS && reg_wdata[gi]) begin
               status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mask <= {`MMC_ST_W{1'b0}};
      end else if (reg_wr && reg_addr == `MMC_OFF_MASK) begin
         mask <= reg_wdata[`MMC_ST_W-1:0];
      end
   end

   assign irq = |(status & mask);

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `MMC_OFF_CONFIG) begin
            reg_rdata <= config_q & `MMC_CONFIG_WMASK; // RULE_07
         end else if (reg_addr == `MMC_OFF_STATUS) begin
            reg_rdata <= {5'h00, status};
         end else if (reg_addr == `MMC_OFF_MASK) begin
            reg_rdata <= {5'h00, mask};
         end else if (reg_addr == `MMC_OFF_ACTIVE) begin
            reg_rdata <= {3'h0, cycle_monitor, other_avg_count == `MMC_AVG_OTHER_FAST,
                          alert_pin_oe, temp_s2, volt_s2};
         end else if (reg_addr == `MMC_OFF_RSVD1) begin
            reg_rdata <= `MMC_RSVD1_VALUE; // RULE_08
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ### src/mmc_consts.vh
`ifndef MMC_CONSTS_VH
`define MMC_CONSTS_VH
// Register offsets on the plain register port
`define MMC_ADDR_W 8
`define MMC_OFF_CONFIG 8'h4f
`define MMC_OFF_STATUS 8'h50
`define MMC_OFF_MASK 8'h51
`define MMC_OFF_ACTIVE 8'h52
`define MMC_OFF_RSVD1 8'h53
// Configuration register fields
`define MMC_BIT_SHUTDOWN 0
`define MMC_BIT_CYCLE 1
`define MMC_BIT_ALERT_EN 2
`define MMC_BIT_VOLT_ALERT 3
`define MMC_BIT_OFS_INT 4
`define MMC_BIT_FAST_AVG 5
`define MMC_CONFIG_RESET 8'h00
`define MMC_CONFIG_WMASK 8'h3f
`define MMC_RSVD1_VALUE 8'hff
// Status / mask layout
`define MMC_ST_SEQ_DONE 0
`define MMC_ST_VOLT_FAULT 1
`define MMC_ST_TEMP_FAULT 2
`define MMC_ST_W 3
// Sample counts for averaging
`define MMC_AVG_REMOTE_SLOW 8'h80
`define MMC_AVG_OTHER_SLOW 8'h08
`define MMC_AVG_REMOTE_FAST 8'h10
`define MMC_AVG_OTHER_FAST 8'h01
`endif

// ### verif/mmc_config_props.sv
`timescale 1ns/1ps
`include "mmc_consts.vh"
module mmc_config_props (
   input wire mclk, rstn, init_n, reg_wr, reg_rd, seq_start, volt_fault, temp_fault,
   input wire vid_pin_role, low_power_shutdown, cycle_monitor, offset_to_internal,
   input wire alert_pin_o, alert_pin_oe, pin_role_alert, pin_role_pulse, irq,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata, remote_avg_count, other_avg_count
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence cfg_wr;
      reg_wr && reg_addr == `MMC_OFF_CONFIG;
   endsequence
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata idle");
   rsvd_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == `MMC_OFF_CONFIG
      |-> reg_rdata[7:6] == 2'h0) else $error("reserved bits");
   read_one_a: assert property ($past(reg_rd) && $past(reg_addr) == `MMC_OFF_RSVD1
      |-> reg_rdata == 8'hff) else $error("read-as-one");
   shut_wr_a: assert property (cfg_wr |=> ##1 low_power_shutdown == $past(reg_wdata[0], 2))
      else $error("low power");
   ofs_wr_a: assert property (cfg_wr |=> ##1 offset_to_internal == $past(reg_wdata[4], 2))
      else $error("offset");
   avg_pair_a: assert property (remote_avg_count == 8'h80 && other_avg_count == 8'h08
      || remote_avg_count == 8'h10 && other_avg_count == 8'h01) else $error("avg");
   // Initialization also reloads the shadows, three edges after the pin falls
   seq_hold_a: assert property (!$past(seq_start) && $past(init_n, 3) |-> $stable(cycle_monitor)
      && $stable(remote_avg_count)) else $error("mid-sequence change");
   role_gate_a: assert property (!pin_role_alert |-> !alert_pin_oe && !alert_pin_o)
      else $error("alert drive");
   role_pass_a: assert property (pin_role_pulse == vid_pin_role) else $error("role");
endmodule
bind mmc_config mmc_config_props chk (.*);

// ### verif/test_monitor_mode_config_register.sv
`timescale 1ns/1ps
`include "mmc_consts.vh"
module test_monitor_mode_config_register;
   reg mclk, rstn, init_n, reg_wr, reg_rd, seq_start, volt_fault, temp_fault, vid_pin_role;
   reg [7:0] reg_addr, reg_wdata;
   wire [7:0] reg_rdata, remote_avg_count, other_avg_count;
   wire low_power_shutdown, cycle_monitor, offset_to_internal;
   wire alert_pin_o, alert_pin_oe, pin_role_alert, pin_role_pulse, irq;
   integer failures = 0, checks_done = 0;
   mmc_config uut (
      .mclk(mclk),
      .rstn(rstn),
      .init_n(init_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .seq_start(seq_start),
      .volt_fault(volt_fault),
      .temp_fault(temp_fault),
      .vid_pin_role(vid_pin_role),
      .low_power_shutdown(low_power_shutdown),
      .cycle_monitor(cycle_monitor),
      .offset_to_internal(offset_to_internal),
      .remote_avg_count(remote_avg_count),
      .other_avg_count(other_avg_count),
      .alert_pin_o(alert_pin_o),
      .alert_pin_oe(alert_pin_oe),
      .pin_role_alert(pin_role_alert),
      .pin_role_pulse(pin_role_pulse),
      .irq(irq)
   );
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   task chk(input [7:0] got, exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
         failures = failures + 1;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task wr(input [7:0] a, d);
      @(posedge mclk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   task rd(input [7:0] a, exp);
      @(posedge mclk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 0;
      #1 chk(reg_rdata, exp);
   endtask
   // One-cycle sequence start, driven on the edge and released on the next
   task pulse;
      @(posedge mclk);
      seq_start <= 1;
      @(posedge mclk);
      seq_start <= 0;
      #1;
   endtask
   task test_reset;
      rd(`MMC_OFF_CONFIG, 8'h00);
      chk(remote_avg_count, 8'h80);
      chk(other_avg_count, 8'h08);
      chk(offset_to_internal, 8'h00);
      chk(cycle_monitor, 8'h00);
      chk(pin_role_alert, 8'h00);
      $display("reset test done");
   endtask
   task test_regs;
      wr(`MMC_OFF_CONFIG, 8'hff);
      rd(`MMC_OFF_CONFIG, 8'h3f);
      wr(`MMC_OFF_RSVD1, 8'h00);
      rd(`MMC_OFF_RSVD1, 8'hff);
      rd(8'h10, 8'h00);
      chk(low_power_shutdown, 8'h01);
      chk(offset_to_internal, 8'h01);
      chk(remote_avg_count, 8'h80);
      chk(cycle_monitor, 8'h00);
      $display("register test done");
   endtask
   task test_avg;
      pulse;
      chk(remote_avg_count, 8'h10);
      chk(other_avg_count, 8'h01);
      chk(cycle_monitor, 8'h01);
      wr(`MMC_OFF_CONFIG, 8'h00);
      pulse;
      chk(remote_avg_count, 8'h80);
      chk(other_avg_count, 8'h08);
      chk(cycle_monitor, 8'h00);
      $display("averaging test done");
   endtask
   task test_alert;
      wr(`MMC_OFF_CONFIG, 8'h04);
      volt_fault <= 1;
      cyc(4);
      chk(alert_pin_oe, 8'h00);
      chk(pin_role_alert, 8'h01);
      chk(irq, 8'h00);
      rd(`MMC_OFF_STATUS, 8'h03);
      wr(`MMC_OFF_MASK, 8'h02);
      cyc(1);
      chk(irq, 8'h01);
      rd(`MMC_OFF_MASK, 8'h02);
      wr(`MMC_OFF_CONFIG, 8'h0c);
      cyc(1);
      chk(alert_pin_oe, 8'h01);
      chk(alert_pin_o, 8'h00);
      wr(`MMC_OFF_STATUS, 8'h02);
      volt_fault <= 0;
      temp_fault <= 1;
      cyc(4);
      chk(irq, 8'h00);
      chk(alert_pin_oe, 8'h01);
      rd(`MMC_OFF_STATUS, 8'h05);
      wr(`MMC_OFF_CONFIG, 8'h08);
      vid_pin_role <= 1;
      temp_fault <= 0;
      cyc(1);
      chk(alert_pin_oe, 8'h00);
      chk(pin_role_alert, 8'h00);
      chk(pin_role_pulse, 8'h01);
      $display("alert test done");
   endtask
   task test_init;
      wr(`MMC_OFF_CONFIG, 8'h3f);
      init_n <= 0;
      cyc(4);
      @(posedge mclk);
      init_n <= 1;
      cyc(3);
      rd(`MMC_OFF_CONFIG, 8'h00);
      chk(low_power_shutdown, 8'h00);
      rd(`MMC_OFF_MASK, 8'h02);
      $display("init test done");
   endtask
   // Mid-run reset clears the mask and is followed at once by a read
   task test_rst;
      wr(`MMC_OFF_MASK, 8'h07);
      rstn <= 0;
      @(posedge mclk);
      rstn <= 1;
      rd(`MMC_OFF_MASK, 8'h00);
      chk(remote_avg_count, 8'h80);
      $display("mid-run reset test done");
   endtask
   task test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {rstn, reg_wr, reg_rd, seq_start, volt_fault, temp_fault, vid_pin_role} = 0;
      init_n = 1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (12) @(posedge mclk);
      rstn <= 1;
      test_reset;
      test_regs;
      test_avg;
      test_alert;
      test_init;
      test_rst;
      test_done;
   end
endmodule
